// ==== src/urx_pkg.sv ====
package urx_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses, one 32-bit word each)
	// ----------------------------------------------------------------
	localparam logic [7:0] MODE_OFS      = 8'h00;
	localparam logic [7:0] SETUP_OFS     = 8'h04;
	localparam logic [7:0] DATA_OFS      = 8'h08;
	localparam logic [7:0] STATUS_OFS    = 8'h0C;
	localparam logic [7:0] FLAG_CLR_OFS  = 8'h10;
	localparam logic [7:0] START_OFS     = 8'h14;
	localparam logic [7:0] STOP_OFS      = 8'h18;
	localparam logic [7:0] STANDBY_OFS   = 8'h1C;
	localparam logic [7:0] PRESCALE_OFS  = 8'h20;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int MODE_LEN_LSB    = 0;  // Two bits of data_length_select.
	localparam int MODE_MSB_BIT    = 2;
	localparam int MODE_INV_BIT    = 3;
	localparam int MODE_PAR_LSB    = 4;  // Two bits of parity mode.
	localparam int MODE_BEMPTY_BIT = 6;  // Buffer-empty interrupt mode, refused.
	localparam int SETUP_RXE_BIT   = 0;
	localparam int SETUP_EOC_BIT   = 1;
	localparam int DATA_DIV_LSB    = 9;
	localparam int STB_SWC_BIT     = 0;
	localparam int STB_SSEC_BIT    = 1;
	localparam int FLAG_OVF_BIT    = 0;
	localparam int FLAG_PEF_BIT    = 1;
	localparam int FLAG_FEF_BIT    = 2;
	localparam int STAT_FULL_BIT   = 3;
	localparam int STAT_EN_BIT     = 4;
	localparam int STAT_BUSY_BIT   = 5;
	localparam int STAT_WAKE_BIT   = 6;

	// ----------------------------------------------------------------
	// Encodings and reset values
	// ----------------------------------------------------------------
	localparam logic [1:0] LEN_9      = 2'h1;
	localparam logic [1:0] LEN_7      = 2'h2;
	localparam logic [1:0] LEN_8      = 2'h3;
	localparam logic [1:0] PAR_NONE   = 2'h0;
	localparam logic [1:0] PAR_ZERO   = 2'h1;
	localparam logic [1:0] PAR_EVEN   = 2'h2;
	localparam logic [1:0] PAR_ODD    = 2'h3;
	localparam logic [1:0] LEN_RST    = 2'h3;
	localparam logic [6:0] DIV_RST    = 7'h7F;
	localparam logic [3:0] PRESC_RST  = 4'h0;
	localparam logic [6:0] DIV_MIN    = 7'h03;  // Fastest rate needs at least this.
	localparam logic [31:0] RDATA_RST = 32'h0000_0000;

	// Frame format carried as one unit.
	typedef struct packed {
		logic [1:0] data_len;
		logic       msb_first;
		logic       invert;
		logic [1:0] parity;
	} urx_cfg_type;

	localparam urx_cfg_type CFG_RST = '{data_len: LEN_RST, msb_first: 1'b0,
		invert: 1'b0, parity: PAR_NONE};

	// Receiver states, one-hot.
	typedef enum logic [5:0] {
		ST_OFF   = 6'h01,
		ST_WAIT  = 6'h02,
		ST_START = 6'h04,
		ST_DATA  = 6'h08,
		ST_PAR   = 6'h10,
		ST_STOP  = 6'h20
	} urx_state_type;

endpackage

// ==== src/urx_receiver.sv ====
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module urx_receiver (
	input  wire logic        sys_clk_i,
	input  wire logic        srst_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	input  wire logic        serial_receive_pin_i,
	input  wire logic        system_stopped_i,
	output logic             rx_done_irq_o,
	output logic             rx_error_irq_o,
	output logic             unit_clock_request_o
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	urx_pkg::urx_cfg_type  cfg_reg;
	urx_pkg::urx_state_type state_reg;
	logic        bempty_reg, rxe_reg, eoc_reg, swc_reg, ssec_reg, en_reg;
	logic [6:0]  div_reg;
	logic [3:0]  presc_reg;
	logic        pin_meta_reg, pin_sync_reg, pin_prev_reg;
	logic        stopped_meta_reg, stopped_reg;
	logic [15:0] pre_cnt_reg;
	logic [8:0]  tick_cnt_reg;
	logic [3:0]  bit_idx_reg;
	logic [8:0]  shift_reg;
	logic [8:0]  rx_data_reg;
	logic        full_reg, ovf_reg, pef_reg, fef_reg, wake_reg, par_bad_reg;
	logic        acc, wr, rd, mapped;
	logic        line, line_prev, start_edge, mck_run, mck_tick, bit_due;
	logic [15:0] pre_mask;
	logic [8:0]  bit_period, half_period;
	logic [3:0]  nbits;
	logic        frame_end, stop_bad, err_ok, par_check, par_calc;
	logic        set_ovf, set_pef, set_fef;
	logic [2:0]  clr_bits;

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	// One wait state so that read data can come from a flip-flop.
	assign acc = psel_i && penable_i && pready_o;
	assign wr  = acc && pwrite_i;
	assign rd  = acc && !pwrite_i;
	always_comb begin
		case (paddr_i)
			urx_pkg::MODE_OFS, urx_pkg::SETUP_OFS, urx_pkg::DATA_OFS,
			urx_pkg::STATUS_OFS, urx_pkg::FLAG_CLR_OFS, urx_pkg::START_OFS,
			urx_pkg::STOP_OFS, urx_pkg::STANDBY_OFS, urx_pkg::PRESCALE_OFS: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	// Handshake: pready rises one cycle into the access phase.
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
		end else begin
			pready_o  <= psel_i && penable_i && !pready_o;
			pslverr_o <= psel_i && penable_i && !pready_o && !mapped;
		end
	end

	// Read data is captured in the cycle before pready rises.
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			prdata_o <= urx_pkg::RDATA_RST;
		end else if (psel_i && penable_i && !pready_o && !pwrite_i) begin
			prdata_o <= 32'h0000_0000;
			case (paddr_i)
				urx_pkg::MODE_OFS: prdata_o[6:0] <= {bempty_reg, cfg_reg.parity,
					cfg_reg.invert, cfg_reg.msb_first, cfg_reg.data_len};
				urx_pkg::SETUP_OFS: prdata_o[1:0] <= {eoc_reg, rxe_reg};
				urx_pkg::DATA_OFS: prdata_o[15:0] <= {div_reg, rx_data_reg};
				urx_pkg::STATUS_OFS: prdata_o[6:0] <= {wake_reg, !state_reg[0] &&
					!state_reg[1], en_reg, full_reg, fef_reg, pef_reg, ovf_reg};
				urx_pkg::STANDBY_OFS: prdata_o[1:0] <= {ssec_reg, swc_reg};
				urx_pkg::PRESCALE_OFS: prdata_o[3:0] <= presc_reg;
				default: prdata_o <= 32'h0000_0000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	// Buffer-empty mode is stored but never steers reception.
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			cfg_reg    <= urx_pkg::CFG_RST;
			bempty_reg <= 1'b0;
			rxe_reg    <= 1'b0;
			eoc_reg    <= 1'b0;
			swc_reg    <= 1'b0;
			ssec_reg   <= 1'b0;
			div_reg    <= urx_pkg::DIV_RST;
			presc_reg  <= urx_pkg::PRESC_RST;
		end else if (wr) begin
			case (paddr_i)
				urx_pkg::MODE_OFS: begin
					cfg_reg.data_len  <= pwdata_i[urx_pkg::MODE_LEN_LSB +: 2];
					cfg_reg.msb_first <= pwdata_i[urx_pkg::MODE_MSB_BIT];
					cfg_reg.invert    <= pwdata_i[urx_pkg::MODE_INV_BIT];
					cfg_reg.parity    <= pwdata_i[urx_pkg::MODE_PAR_LSB +: 2];
					bempty_reg        <= pwdata_i[urx_pkg::MODE_BEMPTY_BIT];
				end
				urx_pkg::SETUP_OFS: begin
					rxe_reg <= pwdata_i[urx_pkg::SETUP_RXE_BIT];
					eoc_reg <= pwdata_i[urx_pkg::SETUP_EOC_BIT];
				end
				urx_pkg::DATA_OFS: div_reg <= pwdata_i[urx_pkg::DATA_DIV_LSB +: 7];
				urx_pkg::STANDBY_OFS: begin
					swc_reg  <= pwdata_i[urx_pkg::STB_SWC_BIT];
					ssec_reg <= pwdata_i[urx_pkg::STB_SSEC_BIT];
				end
				urx_pkg::PRESCALE_OFS: presc_reg <= pwdata_i[3:0];
				default: presc_reg <= presc_reg;
			endcase
		end
	end

	// Channel enabled status: start write sets it, stop write clears it.
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			en_reg <= 1'b0;
		end else if (wr && paddr_i == urx_pkg::START_OFS && pwdata_i[0]) begin
			en_reg <= 1'b1;
		end else if (wr && paddr_i == urx_pkg::STOP_OFS && pwdata_i[0]) begin
			en_reg <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Line synchroniser and operation clock
	// ----------------------------------------------------------------
	// The pin is asynchronous; the first flop feeds nothing but the second.
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			pin_meta_reg     <= 1'b1;
			pin_sync_reg     <= 1'b1;
			pin_prev_reg     <= 1'b1;
			stopped_meta_reg <= 1'b0;
			stopped_reg      <= 1'b0;
		end else begin
			pin_meta_reg     <= serial_receive_pin_i;
			pin_sync_reg     <= pin_meta_reg;
			pin_prev_reg     <= pin_sync_reg;
			stopped_meta_reg <= system_stopped_i;
			stopped_reg      <= stopped_meta_reg;
		end
	end

	// Idle is high on the logical line whatever the polarity.
	assign line       = pin_sync_reg ^ cfg_reg.invert;
	assign line_prev  = pin_prev_reg ^ cfg_reg.invert;
	assign start_edge = line_prev && !line;
	// While stopped in standby, the operation clock is held until a start edge.
	assign mck_run    = !(stopped_reg && swc_reg) || wake_reg;
	assign pre_mask   = 16'((17'h1 << presc_reg) - 17'h1);
	assign mck_tick   = mck_run && ((pre_cnt_reg & pre_mask) == pre_mask);

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			pre_cnt_reg <= 16'h0000;
		end else if (mck_run) begin
			pre_cnt_reg <= pre_cnt_reg + 16'h0001;
		end
	end

	// ----------------------------------------------------------------
	// Frame timing
	// ----------------------------------------------------------------
	// A bit lasts 2*(divider+1) operation clocks; the start is checked at half.
	assign bit_period  = {1'b0, div_reg, 1'b0} + 9'h002;
	assign half_period = {2'b00, div_reg} + 9'h001;
	assign bit_due     = mck_tick && (tick_cnt_reg == ((state_reg == urx_pkg::ST_START) ?
		half_period : bit_period) - 9'h001);
	always_comb begin
		case (cfg_reg.data_len)
			urx_pkg::LEN_9: nbits = 4'h9;
			urx_pkg::LEN_7: nbits = 4'h7;
			default:        nbits = 4'h8;
		endcase
	end
	assign par_check = cfg_reg.parity == urx_pkg::PAR_EVEN ||
		cfg_reg.parity == urx_pkg::PAR_ODD;
	assign par_calc  = ^shift_reg ^ (cfg_reg.parity == urx_pkg::PAR_ODD);
	assign frame_end = (state_reg == urx_pkg::ST_STOP) && bit_due;
	assign stop_bad  = frame_end && !line;
	assign err_ok    = !ssec_reg;
	assign set_fef   = stop_bad && err_ok;
	assign set_pef   = frame_end && par_bad_reg && err_ok;
	assign set_ovf   = frame_end && full_reg && err_ok;

	always_ff @(posedge sys_clk_i) begin
		if (srst_i || state_reg == urx_pkg::ST_OFF || state_reg == urx_pkg::ST_WAIT) begin
			tick_cnt_reg <= 9'h000;
		end else if (bit_due) begin
			tick_cnt_reg <= 9'h000;
		end else if (mck_tick) begin
			tick_cnt_reg <= tick_cnt_reg + 9'h001;
		end
	end

	// ----------------------------------------------------------------
	// Receive state machine
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_i) begin
		if (srst_i || !en_reg) begin
			state_reg <= urx_pkg::ST_OFF;
		end else begin
			case (state_reg)
				urx_pkg::ST_OFF: if (rxe_reg) begin
					state_reg <= urx_pkg::ST_WAIT;
				end
				urx_pkg::ST_WAIT: if (start_edge) begin
					state_reg <= urx_pkg::ST_START;
				end
				// A pulse gone by mid start bit is ignored.
				urx_pkg::ST_START: if (bit_due) begin
					state_reg <= line ? urx_pkg::ST_WAIT : urx_pkg::ST_DATA;
				end
				urx_pkg::ST_DATA: if (bit_due && bit_idx_reg == nbits - 4'h1) begin
					state_reg <= (cfg_reg.parity != urx_pkg::PAR_NONE) ?
						urx_pkg::ST_PAR : urx_pkg::ST_STOP;
				end
				urx_pkg::ST_PAR: if (bit_due) begin
					state_reg <= urx_pkg::ST_STOP;
				end
				urx_pkg::ST_STOP: if (bit_due) begin
					state_reg <= urx_pkg::ST_WAIT;
				end
				default: state_reg <= urx_pkg::ST_OFF;
			endcase
		end
	end

	// Data bits land at their final position so no realignment is needed.
	always_ff @(posedge sys_clk_i) begin
		if (srst_i || state_reg == urx_pkg::ST_START) begin
			shift_reg   <= 9'h000;
			bit_idx_reg <= 4'h0;
			par_bad_reg <= 1'b0;
		end else if (bit_due && state_reg == urx_pkg::ST_DATA) begin
			if (cfg_reg.msb_first) begin
				shift_reg[nbits - 4'h1 - bit_idx_reg] <= line;
			end else begin
				shift_reg[bit_idx_reg] <= line;
			end
			bit_idx_reg <= bit_idx_reg + 4'h1;
		end else if (bit_due && state_reg == urx_pkg::ST_PAR) begin
			par_bad_reg <= par_check && (line != par_calc);
		end
	end

	// ----------------------------------------------------------------
	// Data buffer, error flags and interrupts
	// ----------------------------------------------------------------
	// Writing a 1 clears a flag, but a new error in that cycle wins.
	assign clr_bits = (wr && paddr_i == urx_pkg::FLAG_CLR_OFS) ? pwdata_i[2:0] : 3'h0;
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			ovf_reg <= 1'b0;
			pef_reg <= 1'b0;
			fef_reg <= 1'b0;
		end else begin
			ovf_reg <= (ovf_reg && !clr_bits[urx_pkg::FLAG_OVF_BIT]) || set_ovf;
			pef_reg <= (pef_reg && !clr_bits[urx_pkg::FLAG_PEF_BIT]) || set_pef;
			fef_reg <= (fef_reg && !clr_bits[urx_pkg::FLAG_FEF_BIT]) || set_fef;
		end
	end

	// Newest frame overwrites the buffer; an overrun loses the older word.
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			rx_data_reg <= 9'h000;
			full_reg    <= 1'b0;
		end else if (frame_end) begin
			rx_data_reg <= shift_reg;
			full_reg    <= 1'b1;
		end else if (rd && paddr_i == urx_pkg::DATA_OFS) begin
			full_reg <= 1'b0;
		end
	end

	// Transfer end fires per frame; errors need enable and no suppression.
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			rx_done_irq_o  <= 1'b0;
			rx_error_irq_o <= 1'b0;
		end else begin
			rx_done_irq_o  <= frame_end;
			rx_error_irq_o <= eoc_reg && (set_fef || set_pef || set_ovf);
		end
	end

	// Wake holds the clock request from the start edge to the frame end.
	always_ff @(posedge sys_clk_i) begin
		if (srst_i || state_reg == urx_pkg::ST_OFF) begin
			wake_reg <= 1'b0;
		end else if (stopped_reg && swc_reg && state_reg == urx_pkg::ST_WAIT &&
			start_edge) begin
			wake_reg <= 1'b1;
		end else if (frame_end || (state_reg == urx_pkg::ST_START && bit_due && line)) begin
			wake_reg <= 1'b0;
		end
	end
	assign unit_clock_request_o = wake_reg;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	sequence s_start_write;
		wr && paddr_i == urx_pkg::START_OFS && pwdata_i[0];
	endsequence
	sequence s_frame_done;
		frame_end ##1 rx_done_irq_o;
	endsequence

	property p_start_enables;
		@(posedge sys_clk_i) disable iff (srst_i)
		s_start_write |=> en_reg ##1 (state_reg != urx_pkg::ST_OFF || !rxe_reg || !en_reg);
	endproperty
	a_start_enables: assert property (p_start_enables) else $error("start not taken");

	property p_done_irq;
		@(posedge sys_clk_i) disable iff (srst_i)
		frame_end |-> s_frame_done ##1 !rx_done_irq_o;
	endproperty
	a_done_irq: assert property (p_done_irq) else $error("done pulse wrong");

	property p_fef_set;
		@(posedge sys_clk_i) disable iff (srst_i)
		(frame_end && !line && !ssec_reg) |=> fef_reg;
	endproperty
	a_fef_set: assert property (p_fef_set) else $error("framing flag missed");

	property p_suppress;
		@(posedge sys_clk_i) disable iff (srst_i)
		ssec_reg && !fef_reg && !pef_reg && !ovf_reg |=> !$rose(rx_error_irq_o) && !fef_reg;
	endproperty
	a_suppress: assert property (p_suppress) else $error("error not suppressed");

	property p_overrun;
		@(posedge sys_clk_i) disable iff (srst_i)
		(frame_end && full_reg && !ssec_reg) |=> ovf_reg && full_reg;
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun missed");

	property p_no_err_irq;
		@(posedge sys_clk_i) disable iff (srst_i)
		!eoc_reg |=> !rx_error_irq_o;
	endproperty
	a_no_err_irq: assert property (p_no_err_irq) else $error("error irq unmasked");

	property p_short_pulse;
		@(posedge sys_clk_i) disable iff (srst_i)
		(state_reg == urx_pkg::ST_START && bit_due && line && en_reg) |=>
			state_reg == urx_pkg::ST_WAIT && !wake_reg;
	endproperty
	a_short_pulse: assert property (p_short_pulse) else $error("short pulse took");

	property p_clear;
		@(posedge sys_clk_i) disable iff (srst_i)
		(clr_bits[urx_pkg::FLAG_FEF_BIT] && !set_fef) |=> !fef_reg;
	endproperty
	a_clear: assert property (p_clear) else $error("flag not cleared");

	property p_wake;
		@(posedge sys_clk_i) disable iff (srst_i)
		(stopped_reg && swc_reg && en_reg && state_reg == urx_pkg::ST_WAIT && start_edge)
			|=> unit_clock_request_o && state_reg == urx_pkg::ST_START;
	endproperty
	a_wake: assert property (p_wake) else $error("standby wake missed");

endmodule // urx_receiver

// ==== tb/urx_tx_model.sv ====
`timescale 1ns/1ps
// ------------------------------------------------------------
// Remote transmitter model
// ------------------------------------------------------------
module urx_tx_model (
	input  wire logic sys_clk_i,
	output logic      line_o
);
	initial line_o = 1'b1;

	// Moves the line to the idle level of the chosen polarity between frames.
	task automatic set_idle(input logic inv);
		line_o <= ~inv;
	endtask

	// Start bit, then the bits in wire order, then back to idle; no gap clock is run.
	task automatic send(input logic [11:0] bits, input int n, input logic inv, input int per);
		line_o <= inv;
		repeat (per) @(posedge sys_clk_i);
		for (int k = 0; k < n; k++) begin
			line_o <= bits[k] ^ inv;
			repeat (per) @(posedge sys_clk_i);
		end
		line_o <= ~inv;
	endtask

	// A pulse far shorter than half a bit, so it must never qualify as a start bit.
	task automatic glitch(input int len);
		line_o <= ~line_o;
		repeat (len) @(posedge sys_clk_i);
		line_o <= ~line_o;
	endtask
endmodule // urx_tx_model

// ==== tb/urx_receiver_tb.sv ====
`timescale 1ns/1ps
// ------------------------------------------------------------
// Self-checking bench for the serial receiver
// ------------------------------------------------------------
module urx_receiver_tb;
	localparam int CYC_LIMIT = 30000; // Hang limit, well above the expected run length.
	logic        sys_clk_i, srst_i, psel_i, penable_i, pwrite_i, stopped;
	logic        pready_o, pslverr_o, line, done_irq, err_irq, clk_req;
	logic        rerr, eoc, ssec;
	logic [7:0]  paddr_i;
	logic [31:0] pwdata_i, prdata_o, rdat;
	int          bit_cyc = 8; // System clocks per bit: twice (divider 3 plus one), prescale 0.
	int          done_cnt, err_cnt, req_cnt, cycles, mismatches, samples_checked;

	urx_receiver dut (
		.sys_clk_i            (sys_clk_i),
		.srst_i               (srst_i),
		.psel_i               (psel_i),
		.penable_i            (penable_i),
		.pwrite_i             (pwrite_i),
		.paddr_i              (paddr_i),
		.pwdata_i             (pwdata_i),
		.prdata_o             (prdata_o),
		.pready_o             (pready_o),
		.pslverr_o            (pslverr_o),
		.serial_receive_pin_i (line),
		.system_stopped_i     (stopped),
		.rx_done_irq_o        (done_irq),
		.rx_error_irq_o       (err_irq),
		.unit_clock_request_o (clk_req)
	);

	urx_tx_model tx (
		.sys_clk_i (sys_clk_i),
		.line_o    (line)
	);

	initial begin
		sys_clk_i = 1'b0;
		forever #20 sys_clk_i = ~sys_clk_i;
	end

	// Pulse counters and the cycle count that the hang limit watches.
	always @(posedge sys_clk_i) begin
		cycles <= cycles + 1;
		done_cnt <= srst_i ? 0 : done_cnt + int'(done_irq === 1'b1);
		err_cnt <= srst_i ? 0 : err_cnt + int'(err_irq === 1'b1);
		req_cnt <= srst_i ? 0 : req_cnt + int'(clk_req === 1'b1);
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One APB transfer; ready and read data are taken at the rising edge that commits it.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge sys_clk_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge sys_clk_i);
		penable_i <= 1'b1;
		do begin
			@(posedge sys_clk_i);
			n++;
		end while (pready_o !== 1'b1);
		chk("apb wait", 32'h2, 32'(n));
		rdat = prdata_o;
		rerr = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask

	// Sets the format, then sends one frame in wire order.
	task automatic send_frame(input logic [6:0] m, input logic [8:0] d, input logic bp, input logic bs);
		logic [11:0] v;
		int len;
		int n;
		len = (m[1:0] == urx_pkg::LEN_9) ? 9 : (m[1:0] == urx_pkg::LEN_7) ? 7 : 8;
		v = '0;
		for (n = 0; n < len; n++) v[n] = m[2] ? d[len - 1 - n] : d[n];
		if (m[5:4] != urx_pkg::PAR_NONE) begin
			v[n] = bp ^ (m[5] & ((^d) ^ m[4]));
			n++;
		end
		v[n] = ~bs;
		apb(1'b1, urx_pkg::MODE_OFS, {25'h0, m});
		tx.set_idle(m[3]);
		repeat (3 * bit_cyc) @(posedge sys_clk_i);
		tx.send(v, n + 1, m[3], bit_cyc);
	endtask

	// One frame with all its checks; flags are cleared afterwards.
	task automatic run_case(input logic [6:0] m, input logic [8:0] d, input logic bp, input logic bs);
		int d0;
		int e0;
		logic pe;
		logic fe;
		d0 = done_cnt;
		e0 = err_cnt;
		pe = bp & m[5] & ~ssec;
		fe = bs & ~ssec;
		send_frame(m, d, bp, bs);
		for (int w = 0; w < 4 * bit_cyc && done_cnt == d0; w++) @(posedge sys_clk_i);
		repeat (4) @(posedge sys_clk_i);
		chk("done pulses", 32'(d0 + 1), 32'(done_cnt));
		chk("error pulses", 32'(e0 + int'((pe | fe) & eoc)), 32'(err_cnt));
		apb(1'b0, urx_pkg::DATA_OFS, 32'h0);
		chk("data", {23'h0, d}, {23'h0, rdat[8:0]});
		apb(1'b0, urx_pkg::STATUS_OFS, 32'h0);
		chk("error flags", {29'h0, fe, pe, 1'b0}, {29'h0, rdat[2:0]});
		apb(1'b1, urx_pkg::FLAG_CLR_OFS, 32'h7);
	endtask

	task automatic t_start;
		repeat (4) @(posedge sys_clk_i);
		apb(1'b1, urx_pkg::PRESCALE_OFS, 32'h0);
		apb(1'b0, 8'h40, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, rerr});
		chk("unmapped data", 32'h0, rdat);
		apb(1'b0, urx_pkg::DATA_OFS, 32'h0);
		chk("divider reset", 32'h7F, {25'h0, rdat[15:9]});
		apb(1'b1, urx_pkg::DATA_OFS, 32'h0000_0600);
		apb(1'b1, urx_pkg::SETUP_OFS, 32'h3);
		repeat (4) @(posedge sys_clk_i);
		apb(1'b1, urx_pkg::START_OFS, 32'h1);
		apb(1'b0, urx_pkg::STATUS_OFS, 32'h0);
		chk("enabled", 32'h1, {31'h0, rdat[urx_pkg::STAT_EN_BIT]});
		$display("test start done");
	endtask

	// Every length, order, polarity and parity mode, plus the refused buffer-empty bit.
	task automatic t_formats;
		logic [6:0] m [9] = '{7'h03, 7'h07, 7'h21, 7'h3E, 7'h1B, 7'h43, 7'h23, 7'h13, 7'h03};
		logic [8:0] d [9] = '{9'h0A5, 9'h012, 9'h1A5, 9'h055, 9'h0C3, 9'h081, 9'h05A, 9'h066, 9'h0FF};
		logic [1:0] e [9] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h2};
		for (int i = 0; i < 9; i++) run_case(m[i], d[i], e[i][0], e[i][1]);
		$display("test formats done");
	endtask

	task automatic t_overrun;
		send_frame(7'h03, 9'h00F, 1'b0, 1'b0);
		send_frame(7'h03, 9'h0F0, 1'b0, 1'b0);
		repeat (2 * bit_cyc) @(posedge sys_clk_i);
		apb(1'b0, urx_pkg::STATUS_OFS, 32'h0);
		chk("overrun flag", 32'h1, {31'h0, rdat[urx_pkg::FLAG_OVF_BIT]});
		apb(1'b0, urx_pkg::DATA_OFS, 32'h0);
		chk("newest data", 32'hF0, {23'h0, rdat[8:0]});
		apb(1'b1, urx_pkg::FLAG_CLR_OFS, 32'h1);
		apb(1'b0, urx_pkg::STATUS_OFS, 32'h0);
		chk("flags cleared", 32'h0, {29'h0, rdat[2:0]});
		$display("test overrun done");
	endtask

	task automatic t_masks;
		ssec = 1'b1;
		apb(1'b1, urx_pkg::STANDBY_OFS, 32'h2);
		run_case(7'h23, 9'h05A, 1'b1, 1'b1);
		ssec = 1'b0;
		eoc = 1'b0;
		apb(1'b1, urx_pkg::STANDBY_OFS, 32'h0);
		apb(1'b1, urx_pkg::SETUP_OFS, 32'h1);
		run_case(7'h23, 9'h05A, 1'b1, 1'b0);
		eoc = 1'b1;
		apb(1'b1, urx_pkg::SETUP_OFS, 32'h3);
		$display("test error masks done");
	endtask

	// The standby rate is reprogrammed first; the bench clock stands for the fast oscillator.
	task automatic t_standby;
		int d0;
		int r0;
		apb(1'b1, urx_pkg::DATA_OFS, 32'h0000_D200);
		apb(1'b1, urx_pkg::PRESCALE_OFS, 32'h1);
		bit_cyc = 424;
		apb(1'b1, urx_pkg::STANDBY_OFS, 32'h1);
		stopped <= 1'b1;
		repeat (4) @(posedge sys_clk_i);
		d0 = done_cnt;
		tx.glitch(2);
		repeat (4 * bit_cyc) @(posedge sys_clk_i);
		chk("short pulse", 32'(d0), 32'(done_cnt));
		r0 = req_cnt;
		run_case(7'h03, 9'h0C6, 1'b0, 1'b0);
		chk("clock request", 32'h1, {31'h0, req_cnt > r0});
		stopped <= 1'b0;
		apb(1'b1, urx_pkg::STANDBY_OFS, 32'h0);
		apb(1'b1, urx_pkg::DATA_OFS, 32'h0000_0600);
		apb(1'b1, urx_pkg::PRESCALE_OFS, 32'h0);
		bit_cyc = 8;
		$display("test standby done");
	endtask

	task automatic end_of_test;
		$display("Checks made %0d, mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	initial begin
		srst_i = 1'b1;
		{psel_i, penable_i, pwrite_i, stopped, ssec} = '0;
		paddr_i = 8'h00;
		pwdata_i = 32'h0000_0000;
		eoc = 1'b1;
		{mismatches, samples_checked} = '0;
		repeat (12) @(posedge sys_clk_i);
		srst_i <= 1'b0;
		// The scenarios race the hang limit; whichever ends first leads to the report.
		fork
			begin
				t_start();
				t_formats();
				t_overrun();
				t_masks();
				t_standby();
			end
			begin
				wait (cycles >= CYC_LIMIT);
				mismatches++;
				$display("Timeout after %0d cycles", cycles);
			end
		join_any
		end_of_test();
	end
endmodule // urx_receiver_tb
